// ---- rtl/rcs_pkg.sv ----
// Purpose: Shared constants and types for the reset cause and start-up block
// Assumes: 250 MHz system clock; AXI4-Lite register access
// Notes:   Delay figures are plain defaults; counts derive from them
package rcs_pkg;
    // Clock and timing, times in ns
    localparam int CLK_NS                  = 4;
    localparam int POWER_ON_DELAY_NS       = 10000;
    localparam int REGULATOR_SETTLE_TIME_NS = 10000;
    localparam int POWER_UP_TIMER_PERIOD_NS = 64000000;
    localparam int OSC_START_NS            = 1000;
    localparam int PLL_LOCK_TIME_NS        = 2000000;
    localparam int CLOCK_MONITOR_DELAY_NS  = 100000;
    // Least times, rounded up to whole cycles
    localparam int POWER_ON_DELAY_CYC      = (POWER_ON_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int REGULATOR_SETTLE_CYC    = (REGULATOR_SETTLE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int POWER_UP_TIMER_CYC      = (POWER_UP_TIMER_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int OSC_START_CYC           = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int PLL_LOCK_TIME_CYC       = (PLL_LOCK_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLOCK_MONITOR_DELAY_CYC = (CLOCK_MONITOR_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYCLES             = 8;
    localparam logic [31:0] RESET_VECTOR   = 32'hBFC0_0000;

    // Register map, byte addresses
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] ADDR_CAUSE      = 8'h00;
    localparam logic [7:0] ADDR_SOFT       = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;

    // Cause flag positions
    localparam int POR_BIT   = 0;
    localparam int BOR_BIT   = 1;
    localparam int IDLE_BIT  = 2;
    localparam int SLEEP_BIT = 3;
    localparam int WATCHDOG_EXPIRY_FLAG_BIT  = 4;
    localparam int SWR_BIT   = 6;
    localparam int PIN_RESET_FLAG_BIT  = 7;
    localparam int CM_BIT    = 9;
    localparam logic [31:0] FLAG_MASK      = 32'h0000_02DF;
    localparam logic [31:0] CAUSE_POR_VAL  = 32'h0000_0003;
    localparam logic [31:0] CAUSE_BOR_VAL  = 32'h0000_0002;

    // Soft reset register and status fields
    localparam int SOFT_ARM_BIT  = 0;
    localparam int STAT_CORE_RST = 3;
    localparam int STAT_LP_LSB   = 4;
    localparam int STAT_KIND_LSB = 6;

    // Configuration word 0 fields steering start-up
    localparam int CFG_CRYSTAL = 1;
    localparam int CFG_PLL     = 2;
    localparam int CFG_SWITCH  = 3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_POR_DLY, S_RST_DLY, S_CFG_LOAD, S_OSC, S_LOCK, S_FAILSAFE_CLOCK_MONITOR, S_HOLD, S_RUN
    } rcs_state_t;
    typedef enum logic [1:0] {LP_RUN, LP_IDLE, LP_SLEEP} rcs_lp_t;
    typedef enum logic [1:0] {K_POR, K_BOR, K_OTHER} rcs_kind_t;

    // Device events, one-cycle pulses
    typedef struct packed {
        logic brownout;
        logic watchdog;
        logic wait_idle;
        logic wait_sleep;
        logic wake_irq;
    } rcs_evt_t;
endpackage

// ---- rtl/rcs_reset_cause_and_startup.sv ----
// Purpose: Reset cause flags, configuration reload and start-up sequencing
// Assumes: aresetn is the power-on reset; all inputs synchronous to aclk
// Notes:   Registers over AXI4-Lite; no interrupt output by design
//
// Contract
// RQ1: Every reset reloads the configuration words before the core runs.
// RQ2: Only power-on clears configuration words before reload; others keep them.
// RQ3: Software setting a cause flag never starts a reset.
// RQ4: Software may set or clear any cause flag at any time.
// RQ5: Power-on sets power-on and supply-drop flags, clears others, fetches reset vector.
// RQ6: Supply-drop sets its flag, clears all others, fetches reset vector.
// RQ7: Pin reset in run sets pin flag at bit 7, others unchanged.
// RQ8: Pin reset in idle or sleep sets pin flag, halt flags kept.
// RQ9: Soft reset sets soft flag at bit 6, others unchanged.
// RQ10: Config mismatch reset sets compare flag at bit 9, others unchanged.
// RQ11: Watchdog reset in run sets expiry flag at bit 4, others unchanged.
// RQ12: Watchdog in idle or sleep sets expiry flag, halt flags kept.
// RQ13: Interrupt wake clears expiry flag, keeps halt flags, uses interrupt vector.
// RQ14: Wait instruction sets sleep flag bit 3 or idle flag bit 2.
// RQ15: Power-on and supply-drop both leave the supply-drop flag set; only software clears it.
// RQ16: After power-on, power-on delay, reset delay and start-up all elapse.
// RQ17: Reset delay is regulator settle time, or power-up timer if regulator off.
// RQ18: Power-on and supply-drop load config then wait oscillator, lock, monitor.
// RQ19: Pin, watchdog, soft, mismatch resets use reset delay plus load only.
// RQ20: Core stays in reset 8 more clocks after start-up delays.
// RQ21: No interrupt request and no pin controls.
// RQ22: Writing the trigger arms soft reset; next read starts it next cycle.
// RQ23: Complementary shadow copies compared always; mismatch raises a reset.
// RQ24: Hardware set of a flag wins over a same-cycle software clear.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_and_startup #(
    parameter int CFG_WORDS    = 4,
    parameter int P_POR_CYC    = rcs_pkg::POWER_ON_DELAY_CYC,
    parameter int P_VREG_CYC   = rcs_pkg::REGULATOR_SETTLE_CYC,
    parameter int P_PWRT_CYC   = rcs_pkg::POWER_UP_TIMER_CYC,
    parameter int P_OSC_CYC    = rcs_pkg::OSC_START_CYC,
    parameter int P_LOCK_CYC   = rcs_pkg::PLL_LOCK_TIME_CYC,
    parameter int P_FAILSAFE_CLOCK_MONITOR_CYC   = rcs_pkg::CLOCK_MONITOR_DELAY_CYC
) (
    // Clock and power-on reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite slave
    input  wire logic [rcs_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [rcs_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Device events and straps
    input  wire rcs_pkg::rcs_evt_t           evt,
    input  wire logic                        master_clear_pin_n,
    input  wire logic                        regulator_enable,
    input  wire logic [31:0]                 irq_vector,
    input  wire logic [CFG_WORDS*32-1:0]     nv_cfg,
    input  wire logic [31:0]                 cfg_upset,
    // Core side
    output logic                             core_reset,
    output logic [31:0]                      fetch_addr,
    output logic                             wake_pulse,
    output logic [CFG_WORDS*32-1:0]          cfg_words
);
    import rcs_pkg::*;

    localparam int IDX_W = (CFG_WORDS > 1) ? $clog2(CFG_WORDS) : 1;

    rcs_state_t  state;
    rcs_state_t  next_state;
    rcs_lp_t     lp;
    rcs_kind_t   kind;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [31:0] flags;
    logic [31:0] next_flags;
    logic [31:0] cfg    [CFG_WORDS];
    logic [31:0] shadow [CFG_WORDS];
    logic        soft_armed;
    logic        soft_fire;
    logic        cfg_mismatch;
    logic        done;
    logic        wr_take;
    logic        rd_take;
    logic        wr_cause;
    logic        wr_soft;
    logic        rd_soft;
    logic        pin_rst;
    logic        wdt_rst;
    logic        cmr_evt;
    logic        reset_req;
    logic        lp_wake;
    logic        in_run;
    logic [31:0] rd_val;
    logic        rd_hit;
    logic        wr_hit;

    // Stage length; the reset delay depends on the regulator strap
    function automatic logic [31:0] stage_len(rcs_state_t s);
        logic [31:0] len;
        len = 32'h0000_0001;
        unique case (s)
            S_POR_DLY:  len = 32'(P_POR_CYC);
            S_RST_DLY:  len = regulator_enable ? 32'(P_VREG_CYC) : 32'(P_PWRT_CYC); // RQ17
            S_CFG_LOAD: len = 32'(CFG_WORDS);
            S_OSC:      len = 32'(P_OSC_CYC);
            S_LOCK:     len = 32'(P_LOCK_CYC);
            S_FAILSAFE_CLOCK_MONITOR:     len = 32'(P_FAILSAFE_CLOCK_MONITOR_CYC);
            S_HOLD:     len = 32'(HOLD_CYCLES);
            S_RUN:      len = 32'h0000_0001;
        endcase
        return len;
    endfunction

    // Clock waits only follow power-on and supply-drop resets
    function automatic rcs_state_t after(rcs_state_t s, logic lng, logic [31:0] c0);
        rcs_state_t n;
        n = S_HOLD;
        unique case (s)
            S_POR_DLY:  n = S_RST_DLY; // RQ16
            S_RST_DLY:  n = S_CFG_LOAD;
            S_CFG_LOAD: n = !lng ? S_HOLD : c0[CFG_CRYSTAL] ? S_OSC : c0[CFG_PLL] ? S_LOCK
                          : c0[CFG_SWITCH] ? S_FAILSAFE_CLOCK_MONITOR : S_HOLD; // RQ18 RQ19
            S_OSC:      n = c0[CFG_PLL] ? S_LOCK : c0[CFG_SWITCH] ? S_FAILSAFE_CLOCK_MONITOR : S_HOLD;
            S_LOCK:     n = c0[CFG_SWITCH] ? S_FAILSAFE_CLOCK_MONITOR : S_HOLD;
            S_FAILSAFE_CLOCK_MONITOR:     n = S_HOLD;
            S_HOLD:     n = S_RUN;
            S_RUN:      n = S_RUN;
        endcase
        return n;
    endfunction

    // Reset sources; the watchdog only resets from run
    assign in_run    = (state == S_RUN);
    assign pin_rst   = !master_clear_pin_n;
    assign wdt_rst   = evt.watchdog && in_run && (lp == LP_RUN);
    assign cmr_evt   = cfg_mismatch && in_run; // A standing mismatch would else loop the reset delay
    assign reset_req = evt.brownout || pin_rst || wdt_rst || soft_fire || cmr_evt;
    assign lp_wake   = in_run && (lp != LP_RUN) && (evt.wake_irq || evt.watchdog) && !reset_req;
    assign done      = (cnt == stage_len(state) - 32'h0000_0001);

    // Sequencer next state; any reset source restarts at the reset delay
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (reset_req) begin
            next_state = S_RST_DLY; // RQ16 RQ19
            next_cnt   = '0;
        end else if (state != S_RUN) begin
            if (done) begin
                next_state = after(state, kind != K_OTHER, cfg[0]);
                next_cnt   = '0;
            end else begin
                next_cnt = cnt + 32'h0000_0001;
            end
        end
    end

    // Sequencer state and core reset hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= S_POR_DLY;
            cnt        <= '0;
            core_reset <= 1'b1;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            core_reset <= (next_state != S_RUN); // RQ20
        end
    end

    // Kind of the reset under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kind <= K_POR;
        end else if (reset_req) begin
            kind <= evt.brownout ? K_BOR : K_OTHER;
        end
    end

    // Configuration words with complementary shadows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg[i]    <= '0; // RQ2
                shadow[i] <= '1;
            end
        end else if (state == S_CFG_LOAD) begin
            cfg[cnt[IDX_W-1:0]]    <= nv_cfg[cnt[IDX_W-1:0]*32 +: 32]; // RQ1
            shadow[cnt[IDX_W-1:0]] <= ~nv_cfg[cnt[IDX_W-1:0]*32 +: 32];
        end else begin
            shadow[0] <= shadow[0] ^ cfg_upset; // Upset model for the checker
        end
    end

    // Pair check runs in every mode, sleep included
    always_comb begin
        cfg_mismatch = 1'b0;
        for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_mismatch = cfg_mismatch || |(cfg[i] ~^ shadow[i]); // RQ23
            cfg_words[i*32 +: 32] = cfg[i];
        end
    end

    // Low-power mode follows wait instructions and wakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp <= LP_RUN;
        end else if (reset_req || lp_wake) begin
            lp <= LP_RUN;
        end else if (in_run && evt.wait_sleep) begin
            lp <= LP_SLEEP;
        end else if (in_run && evt.wait_idle) begin
            lp <= LP_IDLE;
        end
    end

    // Fetch address; watchdog wake goes to the reset vector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_addr <= RESET_VECTOR; // RQ5
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= lp_wake;
            if (reset_req) begin
                fetch_addr <= RESET_VECTOR; // RQ6
            end else if (lp_wake) begin
                fetch_addr <= evt.watchdog ? RESET_VECTOR : irq_vector; // RQ13
            end
        end
    end

    // Cause flags: software first, hardware after so its set wins
    always_comb begin
        next_flags = flags;
        if (wr_cause) begin
            for (int b = 0; b < 4; b++) begin
                if (s_axi_wstrb[b]) begin
                    next_flags[b*8 +: 8] = s_axi_wdata[b*8 +: 8]; // RQ4
                end
            end
            next_flags = next_flags & FLAG_MASK; // RQ3
        end
        if (in_run && lp == LP_RUN && evt.wait_sleep) begin
            next_flags[SLEEP_BIT] = 1'b1; // RQ14
        end else if (in_run && lp == LP_RUN && evt.wait_idle) begin
            next_flags[IDLE_BIT] = 1'b1; // RQ14
        end
        if (pin_rst) begin
            next_flags[PIN_RESET_FLAG_BIT] = 1'b1; // RQ7 RQ8 RQ24
        end
        if (soft_fire) begin
            next_flags[SWR_BIT] = 1'b1; // RQ9
        end
        if (cmr_evt) begin
            next_flags[CM_BIT] = 1'b1; // RQ10
        end
        if (evt.watchdog && in_run) begin
            next_flags[WATCHDOG_EXPIRY_FLAG_BIT] = 1'b1; // RQ11 RQ12 RQ24
        end else if (lp_wake && evt.wake_irq) begin
            next_flags[WATCHDOG_EXPIRY_FLAG_BIT] = 1'b0; // RQ13
        end
        if (evt.brownout) begin
            next_flags = CAUSE_BOR_VAL; // RQ6 RQ15
        end
    end

    // Cause flag register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= CAUSE_POR_VAL; // RQ5 RQ15
        end else begin
            flags <= next_flags;
        end
    end

    // Soft reset arm and fire; the fire lands one cycle after the read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_armed <= 1'b0;
            soft_fire  <= 1'b0;
        end else begin
            soft_fire <= rd_soft && soft_armed; // RQ22
            if (reset_req) begin
                soft_armed <= 1'b0;
            end else if (wr_soft && s_axi_wstrb[0]) begin
                soft_armed <= s_axi_wdata[SOFT_ARM_BIT]; // RQ22
            end
        end
    end

    // Bus decode; write address and data are taken together
    assign wr_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rd_take       = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_cause      = wr_take && ({s_axi_awaddr[ADDR_W-1:2], 2'h0} == ADDR_CAUSE);
    assign wr_soft       = wr_take && ({s_axi_awaddr[ADDR_W-1:2], 2'h0} == ADDR_SOFT);
    assign wr_hit        = wr_cause || wr_soft || ({s_axi_awaddr[ADDR_W-1:2], 2'h0} == ADDR_STATUS);
    assign rd_soft       = rd_take && ({s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_SOFT);

    // Read mux; status is read-only, unmapped gets an error
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            ADDR_CAUSE: rd_val = flags;
            ADDR_SOFT:  rd_val[SOFT_ARM_BIT] = soft_armed;
            ADDR_STATUS: begin
                rd_val[2:0]                  = state;
                rd_val[STAT_CORE_RST]        = core_reset;
                rd_val[STAT_LP_LSB +: 2]     = lp;
                rd_val[STAT_KIND_LSB +: 2]   = kind;
            end
            default:    rd_hit = 1'b0;
        endcase
    end

    // Write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // No interrupt request and no pin control leave this block RQ21

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Cycles since power-on release, saturating
    logic [31:0] since_por;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_por <= '0;
        end else if (since_por != 32'hFFFF_FFFF) begin
            since_por <= since_por + 32'h0000_0001;
        end
    end

    sequence s_soft_read;
        rd_take && rd_soft && soft_armed;
    endsequence
    sequence s_soft_fire;
        soft_fire ##1 (state == S_RST_DLY && core_reset);
    endsequence

    a_por_flags: assert property ( // RQ5
        $rose(aresetn) |-> flags == CAUSE_POR_VAL && fetch_addr == RESET_VECTOR && core_reset)
        else $error("power-on flags or vector wrong");
    a_drop_flags: assert property ( // RQ6
        evt.brownout |=> flags == CAUSE_BOR_VAL && state == S_RST_DLY && kind == K_BOR)
        else $error("supply-drop flags wrong");
    a_pin_flag: assert property ( // RQ7
        in_run && pin_rst && !evt.brownout && !soft_fire && !cmr_evt && !evt.watchdog && !wr_cause
        |=> flags[PIN_RESET_FLAG_BIT] && (flags & ~32'h0000_0080) == $past(flags & ~32'h0000_0080))
        else $error("pin reset disturbed other flags");
    a_sw_no_reset: assert property ( // RQ3
        wr_cause && in_run && !reset_req |=> state == S_RUN && !core_reset)
        else $error("flag write started a reset");
    a_soft_trigger: assert property ( // RQ22
        s_soft_read and (!reset_req) |=> s_soft_fire)
        else $error("soft reset not started after read");
    a_hold_eight: assert property ( // RQ20
        $fell(core_reset) |-> $past(state, 1) == S_HOLD && $past(state, 8) == S_HOLD)
        else $error("core released without eight hold cycles");
    a_por_delay: assert property ( // RQ16
        $fell(core_reset) && kind == K_POR |-> since_por > 32'(P_POR_CYC))
        else $error("core released before power-on delay");
    a_set_wins: assert property ( // RQ24
        wr_cause && s_axi_wstrb[0] && !s_axi_wdata[WATCHDOG_EXPIRY_FLAG_BIT] && evt.watchdog && in_run && !evt.brownout
        |=> flags[WATCHDOG_EXPIRY_FLAG_BIT])
        else $error("software clear beat hardware set");
    a_mismatch_rst: assert property ( // RQ23
        cfg_mismatch && in_run && !evt.brownout |=> flags[CM_BIT] && core_reset && state == S_RST_DLY)
        else $error("mismatch did not reset");
    a_short_path: assert property ( // RQ19
        state == S_CFG_LOAD && done && kind == K_OTHER && !reset_req |=> state == S_HOLD)
        else $error("clock waits after a short reset");
    a_irq_wake: assert property ( // RQ13
        lp_wake && evt.wake_irq && !evt.watchdog && !wr_cause
        |=> !flags[WATCHDOG_EXPIRY_FLAG_BIT] && flags[3:2] == $past(flags[3:2]) && fetch_addr == $past(irq_vector)
            && wake_pulse)
        else $error("interrupt wake handled wrongly");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the reset cause and start-up block
// Assumes: Shortened delays; config word 0 enables all three clock waits
// Notes:   Start-up times checked as bounds and differences, not exact edges
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcs_pkg::*;
    // Stimulus driven on the rising edge
    logic           aclk = 0;
    logic           aresetn = 0;
    logic [7:0]     awaddr = '0;
    logic [7:0]     araddr = '0;
    logic           awvalid = 0;
    logic           wvalid = 0;
    logic           arvalid = 0;
    logic [31:0]    wdata = '0;
    logic [3:0]     strb = 4'hF;
    logic           bready = 0;
    logic           rready = 0;
    rcs_evt_t       evt = '0;
    logic           pin_n = 1;
    logic           reg_en = 1;
    logic [31:0]    upset = '0;
    logic [31:0]    irqv = 32'h9D00_0200;
    logic [127:0]   nv = 128'h1111_2222_3333_4444_5555_6666_0000_000E;
    // Design outputs
    logic           awready, wready, bvalid, arready, rvalid, core_reset, wake_pulse;
    logic [1:0]     bresp, rresp;
    logic [31:0]    rdata, fetch_addr, rd;
    logic [127:0]   cfg;
    logic [1:0]     rr;
    int             num_errors = 0;
    int             cmp_count = 0;
    int             c_a, c_b;

    always #2 aclk = ~aclk;

    // Response readies rise with the first request, then stay high; oscillator wait at its default
    rcs_reset_cause_and_startup #(.P_POR_CYC(4), .P_VREG_CYC(3), .P_PWRT_CYC(5),
        .P_LOCK_CYC(3), .P_FAILSAFE_CLOCK_MONITOR_CYC(2)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .evt(evt), .master_clear_pin_n(pin_n), .regulator_enable(reg_en), .irq_vector(irqv),
        .nv_cfg(nv), .cfg_upset(upset), .core_reset(core_reset), .fetch_addr(fetch_addr),
        .wake_pulse(wake_pulse), .cfg_words(cfg));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A used-up wait bound ends the run
    task automatic bound(input int n);
        if (n >= 400) begin
            num_errors++;
            $display("unexpected wait expected done seen timeout");
            give_verdict();
        end
    endtask

    // Write; an event pulse may ride along in the take cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input rcs_evt_t ev, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        evt <= ev;
        do begin
            @(posedge aclk);
            evt <= '0;
            n++;
        end while (!(awready && wready) && n < 400);
        awvalid <= 0;
        wvalid <= 0;
        while (bvalid !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd32(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 400);
        arvalid <= 0;
        while (rvalid !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        d = rdata;
        r = rresp;
        bound(n);
    endtask

    task automatic cause(input logic [31:0] e);
        rd32(ADDR_CAUSE, rd, rr);
        chk("cause", e, rd);
    endtask

    // Counts reset cycles; non-power-on resets must never blank the words
    task automatic run_wait(input bit keep, output int c);
        int n;
        n = 0;
        c = 0;
        while (core_reset !== 1'b1 && n < 10) begin
            @(posedge aclk);
            n++;
        end
        chk("reset seen", 32'h1, {31'h0, core_reset === 1'b1});
        while (core_reset === 1'b1 && c < 400) begin
            @(posedge aclk);
            c++;
            if (keep && cfg === '0) chk("cfg kept", 32'h1, 32'h0);
        end
        bound(c);
        chk("fetch", RESET_VECTOR, fetch_addr);
        chk("cfg", nv[31:0], cfg[31:0]);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        run_wait(0, c_a);
        chk("por time", 32'h1, {31'h0, c_a >= 24 + OSC_START_CYC});
        cause(CAUSE_POR_VAL);
        wr(ADDR_CAUSE, 32'h0, '0, RESP_OKAY);
        cause(32'h0);
        wr(ADDR_CAUSE, FLAG_MASK, '0, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk("no reset", 32'h0, {31'h0, core_reset});
        cause(FLAG_MASK);
        wr(ADDR_CAUSE, 32'h10, 5'b00100, RESP_OKAY);
        cause(32'h1 << IDLE_BIT | 32'h1 << WATCHDOG_EXPIRY_FLAG_BIT);
        wr(ADDR_STATUS, 32'h0, 5'b00001, RESP_OKAY);
        chk("irq pulse", 32'h1, {31'h0, wake_pulse});
        chk("irq wake", irqv, fetch_addr);
        cause(32'h1 << IDLE_BIT);
        wr(ADDR_STATUS, 32'h0, 5'b00010, RESP_OKAY);
        wr(ADDR_CAUSE, 32'hC, 5'b01000, RESP_OKAY);
        chk("wdt pulse", 32'h1, {31'h0, wake_pulse});
        repeat (2) @(posedge aclk);
        chk("wdt wake", RESET_VECTOR, fetch_addr);
        chk("no reset", 32'h0, {31'h0, core_reset});
        cause(32'h1 << IDLE_BIT | 32'h1 << SLEEP_BIT | 32'h1 << WATCHDOG_EXPIRY_FLAG_BIT);
        // Pin reset from idle, with new words to reload
        wr(ADDR_CAUSE, 32'h0, '0, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0, 5'b00100, RESP_OKAY);
        nv[127:96] <= 32'hA5A5_0F0F;
        pin_n <= 0;
        repeat (2) @(posedge aclk);
        pin_n <= 1;
        run_wait(1, c_a);
        chk("cfg reload", 32'hA5A5_0F0F, cfg[127:96]);
        chk("pin time", 32'h1, {31'h0, c_a >= 15 && c_a <= 24});
        cause(32'h1 << PIN_RESET_FLAG_BIT | 32'h1 << IDLE_BIT);
        // Same pin reset with the regulator off
        reg_en <= 0;
        pin_n <= 0;
        repeat (2) @(posedge aclk);
        pin_n <= 1;
        run_wait(1, c_b);
        chk("pwrt delta", 32'd2, 32'(c_b - c_a));
        cause(32'h1 << PIN_RESET_FLAG_BIT | 32'h1 << IDLE_BIT);
        // Soft reset: arming alone does nothing
        wr(ADDR_CAUSE, 32'h0, '0, RESP_OKAY);
        wr(ADDR_SOFT, 32'h1, '0, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("armed only", 32'h0, {31'h0, core_reset});
        rd32(ADDR_SOFT, rd, rr);
        chk("soft armed", 32'h1, rd);
        run_wait(1, c_a);
        cause(32'h1 << SWR_BIT);
        wr(ADDR_STATUS, 32'h0, 5'b01000, RESP_OKAY);
        run_wait(1, c_a);
        cause(32'h1 << SWR_BIT | 32'h1 << WATCHDOG_EXPIRY_FLAG_BIT);
        upset <= 32'h1;
        @(posedge aclk);
        upset <= 32'h0;
        run_wait(1, c_a);
        cause(32'h1 << SWR_BIT | 32'h1 << WATCHDOG_EXPIRY_FLAG_BIT | 32'h1 << CM_BIT);
        strb <= 4'h1;
        wr(ADDR_CAUSE, 32'h0, '0, RESP_OKAY);
        strb <= 4'hF;
        cause(32'h1 << CM_BIT);
        wr(ADDR_STATUS, 32'h0, 5'b10000, RESP_OKAY);
        run_wait(1, c_b);
        chk("bor waits", 32'h1, {31'h0, c_b >= c_a + OSC_START_CYC});
        cause(CAUSE_BOR_VAL);
        rd32(ADDR_STATUS, rd, rr);
        chk("status", 32'h47, rd);
        rd32(8'h0C, rd, rr);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        chk("unmapped data", 32'h0, rd);
        wr(8'h0C, 32'h1, '0, RESP_SLVERR);
        give_verdict();
    end
endmodule
`default_nettype wire
